// *** rtl/break_condition_pkg.sv ***
package break_condition_pkg;
    // Monitored processor bus cycle
    typedef struct packed {
        logic        valid;
        logic        is_insn;
        logic        is_write;
        logic [2:0]  size;
        logic [7:0]  space_id;
        logic [31:0] addr;
        logic [31:0] data;
    } bus_cycle_t;
    // Register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;
    // One channel's comparison setup
    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  space_id;
        logic [3:0]  mask;
        logic [6:0]  qual;
    } chan_setup_t;
endpackage

// *** rtl/break_condition_registers.sv ***
// Contract
// - Channel A 32-bit break address, read/write
// - Channel A address survives resets, undefined
// - Channel A 8-bit space id, read/write
// - Channel A space id not reset
// - Mask bit 2 ignores whole space id
// - Mask bits 3,1,0 select low-bit address mask
// - Unused mask and qualifier bits read zero
// - Qualifier register reset to zero only
// - Qualifier bits 5:4 select access type
// - Qualifier bits 3:2 select direction
// - Qualifier bits 6,1,0 select operand size
// - Channel B mirrors channel A layout
// - Channel B 32-bit break data register
// - Channel B data not reset
// - Mask applies to id and address
// - Match sets channel A flag bit 15
// - Data compare only when enable bit set
`timescale 1ns/1ps
`include "break_condition_regs.svh"
module break_condition_registers
    import break_condition_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire reg_req_t    req,
    input  wire bus_cycle_t  cyc,
    output logic [31:0]      rdata,
    output logic             chan_a_match,
    output logic             chan_b_match,
    output logic             irq
);
    // ==========================================================
    // State
    typedef struct packed {
        chan_setup_t a;          // Channel A setup
        chan_setup_t b;          // Channel B setup
        logic [31:0] b_data;     // Channel B break data
        logic        data_en;    // Data compare enable
        logic        flag_a;     // Sticky match flags
        logic        flag_b;
        logic [1:0]  irq_stat;   // Interrupt status
        logic [1:0]  irq_mask;   // Interrupt mask
        logic [31:0] rdata;
        logic        match_a;
        logic        match_b;
        logic        irq;
    } state_t;

    state_t st;
    state_t next_st;
    logic   hit_a;               // Combinational channel matches
    logic   hit_b;

    // ==========================================================
    // Address mask from three-bit code
    function automatic logic [31:0] addr_care(input logic [3:0] m);
        logic [2:0] code;
        code = {m[3], m[1], m[0]};
        case (code)
            3'h0:    addr_care = 32'hFFFFFFFF;
            3'h1:    addr_care = 32'hFFFFFC00;
            3'h2:    addr_care = 32'hFFFFF000;
            3'h3:    addr_care = 32'h00000000;
            3'h4:    addr_care = 32'hFFFF0000;
            3'h5:    addr_care = 32'hFFF00000;
            // Reserved codes: compare all bits, a harmless choice
            default: addr_care = 32'hFFFFFFFF;
        endcase
    endfunction

    // Qualifier check shared by both channels
    function automatic logic qual_ok(input logic [6:0] q, input bus_cycle_t c);
        logic ok_type;
        logic ok_dir;
        logic ok_size;
        logic [2:0] sz;
        // Code 00 means no comparison, so it always matches
        ok_type = (q[5:4] == 2'h0) || (c.is_insn ? q[4] : q[5]);
        ok_dir  = (q[3:2] == 2'h0) || (c.is_write ? q[3] : q[2]);
        sz      = {q[`QUAL_SIZE_HI], q[1:0]};
        ok_size = (sz == 3'h0) || (sz == c.size);
        qual_ok = ok_type && ok_dir && ok_size;
    endfunction

    // Full channel comparison
    function automatic logic chan_hit(input chan_setup_t s, input bus_cycle_t c);
        logic [31:0] care;
        logic        id_ok;
        care  = addr_care(s.mask);
        // Space id is all-or-nothing
        id_ok = s.mask[`MASK_SPACE_BIT] || (s.space_id == c.space_id);
        chan_hit = c.valid && id_ok && (((s.addr ^ c.addr) & care) == 32'h0)
                   && qual_ok(s.qual, c);
    endfunction

    // ==========================================================
    // Matches
    always_comb begin
        hit_a = chan_hit(st.a, cyc);
        // Data only takes part when enabled
        hit_b = chan_hit(st.b, cyc) &&
                (!st.data_en || (st.b_data == cyc.data));
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_st         = st;
        next_st.match_a = hit_a;
        next_st.match_b = hit_b;
        next_st.rdata   = 32'h0;
        // Register writes
        if (req.wr) begin
            case (req.addr)
                `OFS_A_ADDR:  next_st.a.addr = req.wdata;
                `OFS_A_SPACE: next_st.a.space_id = req.wdata[7:0];
                `OFS_A_MASK:  next_st.a.mask = req.wdata[3:0];
                `OFS_A_QUAL:  next_st.a.qual = req.wdata[6:0];
                `OFS_B_ADDR:  next_st.b.addr = req.wdata;
                `OFS_B_SPACE: next_st.b.space_id = req.wdata[7:0];
                `OFS_B_MASK:  next_st.b.mask = req.wdata[3:0];
                `OFS_B_QUAL:  next_st.b.qual = req.wdata[6:0];
                `OFS_B_DATA:  next_st.b_data = req.wdata;
                `OFS_CONTROL: begin
                    next_st.data_en = req.wdata[`CTRL_DATA_EN];
                    next_st.flag_a  = req.wdata[`CTRL_FLAG_A];
                    next_st.flag_b  = req.wdata[`CTRL_FLAG_B];
                end
                `OFS_IRQ_STATUS: next_st.irq_stat = st.irq_stat & ~req.wdata[1:0];
                `OFS_IRQ_MASK:   next_st.irq_mask = req.wdata[1:0];
                default: ;
            endcase
        end
        // Hardware set wins over a software clear
        if (hit_a) begin
            next_st.flag_a      = 1'b1;
            next_st.irq_stat[0] = 1'b1;
        end
        if (hit_b) begin
            next_st.flag_b      = 1'b1;
            next_st.irq_stat[1] = 1'b1;
        end
        // Reads: data the cycle after; unused bits zero
        if (req.rd) begin
            case (req.addr)
                `OFS_A_ADDR:  next_st.rdata = st.a.addr;
                `OFS_A_SPACE: next_st.rdata = {24'h0, st.a.space_id};
                `OFS_A_MASK:  next_st.rdata = {28'h0, st.a.mask};
                `OFS_A_QUAL:  next_st.rdata = {25'h0, st.a.qual};
                `OFS_B_ADDR:  next_st.rdata = st.b.addr;
                `OFS_B_SPACE: next_st.rdata = {24'h0, st.b.space_id};
                `OFS_B_MASK:  next_st.rdata = {28'h0, st.b.mask};
                `OFS_B_QUAL:  next_st.rdata = {25'h0, st.b.qual};
                `OFS_B_DATA:  next_st.rdata = st.b_data;
                `OFS_CONTROL: next_st.rdata = {16'h0, st.flag_a, st.flag_b, 6'h0,
                                               st.data_en, 7'h0};
                `OFS_IRQ_STATUS: next_st.rdata = {30'h0, st.irq_stat};
                `OFS_IRQ_MASK:   next_st.rdata = {30'h0, st.irq_mask};
                default:         next_st.rdata = 32'h0;   // Unmapped reads zero
            endcase
        end
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    end

    // ==========================================================
    // Registers: setup values other than the qualifiers keep contents over reset
    always_ff @(posedge sys_clk) begin
        st <= next_st;
        if (sys_rst) begin
            st.a.qual   <= 7'(`QUAL_RESET);
            st.b.qual   <= 7'(`QUAL_RESET);
            st.flag_a   <= 1'b0;
            st.flag_b   <= 1'b0;
            st.irq_stat <= 2'h0;
            st.irq_mask <= 2'h0;
            st.rdata    <= 32'h0;
            st.match_a  <= 1'b0;
            st.match_b  <= 1'b0;
            st.irq      <= 1'b0;
        end
    end

    assign rdata        = st.rdata;
    assign chan_a_match = st.match_a;
    assign chan_b_match = st.match_b;
    assign irq          = st.irq;

    // ==========================================================
    // Checks
    // Setup registers other than the qualifiers hold X until written, so the gate checks below only
    // trigger once their antecedent fields are known values.

    // A channel A hit always raises its sticky flag
    chk_flag_a_set: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        hit_a |=> st.flag_a)
        else $error("flag a not set");
    // Only a control write may lower the flag
    chk_flag_a_hold: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        st.flag_a && !(req.wr && req.addr == `OFS_CONTROL) |=> st.flag_a)
        else $error("flag a cleared by hardware");
    // Channel B flag follows its own hits
    chk_flag_b_set: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        hit_b |=> st.flag_b)
        else $error("flag b not set");
    // Without a hit the written value lands in the flag
    chk_flag_a_write: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        req.wr && req.addr == `OFS_CONTROL && !hit_a
        |=> st.flag_a == $past(req.wdata[`CTRL_FLAG_A]))
        else $error("flag a write lost");
    // Unused qualifier bits read zero
    chk_qual_read: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        req.rd && req.addr == `OFS_A_QUAL |=> rdata[31:7] == 25'h0)
        else $error("qualifier upper bits nonzero");
    // Unused mask bits read zero
    chk_mask_read: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        req.rd && req.addr == `OFS_B_MASK |=> rdata[31:4] == 28'h0)
        else $error("mask upper bits nonzero");
    // Control readback shows only the three live bits
    chk_ctrl_read: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        req.rd && req.addr == `OFS_CONTROL
        |=> rdata[31:16] == 16'h0 && rdata[13:8] == 6'h0 && rdata[6:0] == 7'h0)
        else $error("control unused bits nonzero");
    // Space id is eight bits wide on the bus
    chk_space_read: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        req.rd && req.addr == `OFS_A_SPACE |=> rdata[31:8] == 24'h0)
        else $error("space id upper bits nonzero");
    // Read data stands only in the cycle after a read
    chk_rdata_idle: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !req.rd |=> rdata == 32'h0)
        else $error("read data without read");
    // Back-to-back write and read return the written address
    chk_addr_wr: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        req.wr && req.addr == `OFS_A_ADDR ##1 req.rd && req.addr == `OFS_A_ADDR
        |=> rdata == $past(req.wdata, 2))
        else $error("address readback wrong");
    // Channel B address takes the full word
    chk_b_addr_wr: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        req.wr && req.addr == `OFS_B_ADDR |=> st.b.addr == $past(req.wdata))
        else $error("channel b address not stored");
    // Space id keeps the low byte
    chk_space_wr: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        req.wr && req.addr == `OFS_A_SPACE |=> st.a.space_id == $past(req.wdata[7:0]))
        else $error("space id not stored");
    // Qualifier keeps its seven live bits
    chk_qual_wr: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        req.wr && req.addr == `OFS_A_QUAL |=> st.a.qual == $past(req.wdata[6:0]))
        else $error("qualifier not stored");
    // Break data takes the full word
    chk_data_wr: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        req.wr && req.addr == `OFS_B_DATA |=> st.b_data == $past(req.wdata))
        else $error("break data not stored");
    // Mask keeps its four live bits
    chk_mask_wr: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        req.wr && req.addr == `OFS_A_MASK |=> st.a.mask == $past(req.wdata[3:0]))
        else $error("mask not stored");
    // Reset clears both qualifiers
    chk_qual_reset: assert property (
        @(posedge sys_clk)
        sys_rst |=> st.a.qual == 7'h0 && st.b.qual == 7'h0)
        else $error("qualifier not reset");
    // Outputs are quiet right after a reset edge
    chk_rst_outputs: assert property (
        @(posedge sys_clk)
        sys_rst |=> !chan_a_match && !chan_b_match && !irq && rdata == 32'h0)
        else $error("outputs not cleared by reset");
    // No bus cycle, no match
    chk_invalid_nohit: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !cyc.valid |=> !chan_a_match && !chan_b_match)
        else $error("match without bus cycle");
    // Match output follows the hit one cycle later
    chk_match_a_reg: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        hit_a |=> chan_a_match)
        else $error("channel a match lost");
    // Same for channel B
    chk_match_b_reg: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        hit_b |=> chan_b_match)
        else $error("channel b match lost");
    // Full address compare rejects any differing bit
    chk_addr_gate: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        cyc.valid && {st.a.mask[3], st.a.mask[1], st.a.mask[0]} == 3'h0
        && cyc.addr != st.a.addr |=> !chan_a_match)
        else $error("address compare ignored");
    // Space id compared unless the ignore bit is set
    chk_space_gate: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        cyc.valid && !st.a.mask[`MASK_SPACE_BIT] && cyc.space_id != st.a.space_id
        |=> !chan_a_match)
        else $error("space id compare ignored");
    // Fetch-only setting rejects operand cycles
    chk_type_gate: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        cyc.valid && st.a.qual[5:4] == 2'h1 && !cyc.is_insn |=> !chan_a_match)
        else $error("access type ignored");
    // Read-only setting rejects write cycles
    chk_dir_gate: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        cyc.valid && st.a.qual[3:2] == 2'h1 && cyc.is_write |=> !chan_a_match)
        else $error("direction ignored");
    // A selected size rejects every other size
    chk_size_gate: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        cyc.valid && {st.a.qual[6], st.a.qual[1:0]} != 3'h0
        && {st.a.qual[6], st.a.qual[1:0]} != cyc.size |=> !chan_a_match)
        else $error("size ignored");
    // Data compare blocks channel B when enabled
    chk_data_gate: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        st.data_en && cyc.data != st.b_data |=> !chan_b_match)
        else $error("data compare ignored");
    // Interrupt level tracks status and mask
    chk_irq_level: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        ##1 irq == |(st.irq_stat & st.irq_mask))
        else $error("irq mismatch");
    // Write-one clears a status bit when no new hit lands
    chk_irq_clear: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        req.wr && req.addr == `OFS_IRQ_STATUS && req.wdata[0] && !hit_a
        |=> !st.irq_stat[0])
        else $error("status bit not cleared");

    // ==========================================================
    // Scenario covers
    cov_hit_a: cover property (@(posedge sys_clk) chan_a_match);
    cov_hit_b: cover property (@(posedge sys_clk) chan_b_match && st.data_en);
    cov_irq:   cover property (@(posedge sys_clk) irq);
    cov_b2b:   cover property (@(posedge sys_clk) req.wr ##1 req.rd);
    cov_miss:  cover property (@(posedge sys_clk) cyc.valid && st.data_en && !hit_b);
endmodule

// *** rtl/break_condition_regs.svh ***
`ifndef BREAK_CONDITION_REGS_SVH
`define BREAK_CONDITION_REGS_SVH
// ==========================================================
// Register offsets (byte addresses)
`define OFS_A_ADDR      8'h00
`define OFS_A_MASK      8'h04
`define OFS_A_QUAL      8'h08
`define OFS_B_ADDR      8'h0C
`define OFS_B_MASK      8'h10
`define OFS_B_QUAL      8'h14
`define OFS_B_DATA      8'h18
`define OFS_CONTROL     8'h20
`define OFS_A_SPACE     8'h24
`define OFS_B_SPACE     8'h28
`define OFS_IRQ_STATUS  8'h2C
`define OFS_IRQ_MASK    8'h30
// ==========================================================
// Field positions
`define MASK_SPACE_BIT  2
`define QUAL_SIZE_HI    6
`define CTRL_FLAG_A     15
`define CTRL_FLAG_B     14
`define CTRL_DATA_EN    7
// ==========================================================
// Reset values and writable masks
`define QUAL_RESET      16'h0000
`define QUAL_WMASK      16'h007F
`define MASK_WMASK      8'h0F
`define CTRL_WMASK      16'h0080
`endif

// *** tb/break_condition_registers_test.sv ***
`timescale 1ns/1ps
`include "break_condition_regs.svh"
module break_condition_registers_test
    import break_condition_pkg::*;
;
    localparam logic [31:0] BASE = 32'h8765_4321;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    reg_req_t    req = '0;
    bus_cycle_t  cyc;
    bus_cycle_t  c;
    logic [31:0] rdata;
    logic        chan_a_match;
    logic        chan_b_match;
    logic        irq;
    int          miscompares = 0;
    int          comparisons = 0;
    // ==========================================
    // Clock, design and bus partner
    always #12.5 sys_clk = ~sys_clk;
    break_condition_registers uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .cyc(cyc),
        .rdata(rdata), .chan_a_match(chan_a_match), .chan_b_match(chan_b_match), .irq(irq));
    cpu_cycle_model cpu (.sys_clk(sys_clk), .cyc(cyc));
    // ==========================================
    // Shared bus and compare tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Release costs an edge so the strobe is never assigned twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        req <= '0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge sys_clk);
        req <= '0;
        #1 chk("rdata", rdata, e);
        @(posedge sys_clk);
    endtask
    task automatic fire(input bus_cycle_t v, input logic ea, input logic eb);
        cpu.issue(v);
        #1 chk("match_a", {31'h0, chan_a_match}, {31'h0, ea});
        chk("match_b", {31'h0, chan_b_match}, {31'h0, eb});
        @(posedge sys_clk);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs;
        logic [7:0]  ofs [10] = '{`OFS_A_ADDR, `OFS_A_SPACE, `OFS_A_MASK, `OFS_A_QUAL,
            `OFS_B_ADDR, `OFS_B_SPACE, `OFS_B_MASK, `OFS_B_QUAL, `OFS_B_DATA, 8'h3C};
        logic [31:0] msk [10] = '{32'hFFFFFFFF, 32'hFF, 32'h0F, 32'h7F,
            32'hFFFFFFFF, 32'hFF, 32'h0F, 32'h7F, 32'hFFFFFFFF, 32'h0};
        rd(`OFS_A_QUAL, 32'h0);
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 10; i++) begin
                wr(ofs[i], p ? 32'hFFFFFFFF : 32'h5A5AA5A5);
                rd(ofs[i], msk[i] & (p ? 32'hFFFFFFFF : 32'h5A5AA5A5));
            end
        end
        // Write then read with no idle cycle between the strobes
        req <= '{wr: 1'b1, rd: 1'b0, addr: `OFS_A_ADDR, wdata: 32'h1234ABCD};
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: `OFS_A_ADDR, wdata: 32'h0};
        @(posedge sys_clk);
        req <= '0;
        #1 chk("rdata", rdata, 32'h1234ABCD);
        @(posedge sys_clk);
        wr(`OFS_A_ADDR, 32'h5A5AA5A5);
        wr(`OFS_A_SPACE, 32'hA5);
        wr(`OFS_B_DATA, 32'h5A5AA5A5);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rd(`OFS_A_ADDR, 32'h5A5AA5A5);
        rd(`OFS_A_SPACE, 32'hA5);
        rd(`OFS_B_DATA, 32'h5A5AA5A5);
        rd(`OFS_A_QUAL, 32'h0);
        rd(`OFS_B_QUAL, 32'h0);
    endtask
    task automatic t_amask;
        int          n [6] = '{0, 10, 12, 32, 16, 20};
        logic [31:0] code [6] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h8, 32'h9};
        c = '{valid: 1'b1, is_insn: 1'b0, is_write: 1'b0, size: 3'd1, space_id: 8'h11,
            addr: BASE, data: 32'h0};
        wr(`OFS_CONTROL, 32'h0);
        wr(`OFS_B_ADDR, 32'hFFFFFFF0);
        wr(`OFS_B_MASK, 32'h0);
        wr(`OFS_B_SPACE, 32'hEE);
        wr(`OFS_A_ADDR, BASE);
        wr(`OFS_A_SPACE, 32'h11);
        wr(`OFS_A_QUAL, 32'h0);
        // Reserved codes are never programmed
        for (int i = 0; i < 6; i++) begin
            wr(`OFS_A_MASK, code[i]);
            c.addr = BASE ^ (n[i] == 0 ? 32'h0 : 32'h1 << (n[i] - 1));
            fire(c, 1'b1, 1'b0);
            c.addr = BASE ^ (32'h1 << (n[i] % 32));
            if (n[i] != 32) fire(c, 1'b0, 1'b0);
        end
        c.addr = BASE;
        wr(`OFS_A_MASK, 32'h0);
        c.space_id = 8'h12;
        fire(c, 1'b0, 1'b0);
        wr(`OFS_A_MASK, 32'h4);
        fire(c, 1'b1, 1'b0);
        c.space_id = 8'h11;
    endtask
    task automatic t_qual;
        for (int k = 0; k < 4; k++) begin
            wr(`OFS_A_QUAL, 32'(k << 4));
            for (int b = 0; b < 2; b++) begin
                c.is_insn = b[0];
                fire(c, k == 0 || (k[0] && b[0]) || (k[1] && !b[0]), 1'b0);
            end
            c.is_insn = 1'b0;
            wr(`OFS_A_QUAL, 32'(k << 2));
            for (int b = 0; b < 2; b++) begin
                c.is_write = b[0];
                fire(c, k == 0 || (k[0] && !b[0]) || (k[1] && b[0]), 1'b0);
            end
            c.is_write = 1'b0;
        end
        for (int k = 0; k < 5; k++) begin
            wr(`OFS_A_QUAL, {25'h0, k[2], 4'h0, k[1:0]});
            for (int s = 1; s < 5; s++) begin
                c.size = 3'(s);
                fire(c, k == 0 || k == s, 1'b0);
            end
        end
        c.size = 3'd1;
        wr(`OFS_A_QUAL, 32'h0);
    endtask
    task automatic t_data;
        wr(`OFS_B_ADDR, BASE);
        wr(`OFS_B_SPACE, 32'h11);
        wr(`OFS_B_DATA, 32'h0F0F1234);
        fire(c, 1'b1, 1'b1);
        wr(`OFS_CONTROL, 32'h80);
        fire(c, 1'b1, 1'b0);
        c.data = 32'h0F0F1234;
        fire(c, 1'b1, 1'b1);
        wr(`OFS_B_ADDR, 32'hFFFFFFF0);
    endtask
    task automatic t_irq;
        wr(`OFS_CONTROL, 32'h0);
        wr(`OFS_IRQ_STATUS, 32'h3);
        wr(`OFS_IRQ_MASK, 32'h0);
        rd(`OFS_CONTROL, 32'h0);
        fire(c, 1'b1, 1'b0);
        rd(`OFS_CONTROL, 32'h8000);
        rd(`OFS_IRQ_STATUS, 32'h1);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(`OFS_IRQ_MASK, 32'h1);
        #1 chk("irq", {31'h0, irq}, 32'h1);
        wr(`OFS_IRQ_STATUS, 32'h1);
        #1 chk("irq", {31'h0, irq}, 32'h0);
        rd(`OFS_CONTROL, 32'h8000);
        wr(`OFS_CONTROL, 32'h0);
        rd(`OFS_CONTROL, 32'h0);
    endtask
    // ==========================================
    // Verdict, main sequence and watchdog
    task automatic tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_regs();
        t_amask();
        t_qual();
        t_data();
        t_irq();
        tally_and_finish();
    end
    // Run needs well under 1500 cycles
    initial begin
        #(25 * 5000);
        miscompares++;
        tally_and_finish();
    end
endmodule

// *** tb/cpu_cycle_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Processor bus cycles seen by the break unit
module cpu_cycle_model
    import break_condition_pkg::*;
(
    input  wire logic sys_clk,
    output bus_cycle_t cyc
);
    initial cyc = '0;
    // One cycle per call; afterwards fields go stale-inverted so no old value lingers
    task automatic issue(input bus_cycle_t c);
        cyc <= c;
        @(posedge sys_clk);
        cyc <= {1'b0, ~c[$bits(c)-2:0]};
    endtask
endmodule
